// >>> rbc_regs.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rbc_regs #(
  parameter int CAL_CYCLES = rbc_pkg::RF_CAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cryptoDone,
  input wire logic strengthDone,
  output logic sleepRequest,
  output logic [8:0] oscillatorWakeCount,
  output logic rfMachineReset,
  output logic rfCalibrating,
  output logic [1:0] rfModeBits,
  output logic decryptStart,
  output logic encryptStart,
  output logic cryptoBusy,
  output logic [2:0] slot2SuiteSelect,
  output logic [2:0] slot1SuiteSelect,
  output logic turboRate,
  output logic symbolSignInvert,
  output logic [1:0] channelAssessmentMode,
  output logic [3:0] assessmentCarrierThreshold,
  output logic [3:0] preambleValidThreshold,
  output logic [2:0] preambleDetectThreshold,
  output logic [2:0] carrierSenseThreshold,
  output logic [2:0] preambleCounterThreshold,
  output logic strengthStart,
  output logic perPacketStrength
);
  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (CAL_CYCLES < 1) begin : g_bad
    $error("CAL_CYCLES must be at least one");
  end
  // command bits are strobes, never stored, so the masks must leave them out
  if (rbc_pkg::MASK_SLEEP[rbc_pkg::BIT_SLEEP_CMD] != 1'b0) begin : g_bad_sleep
    $error("sleep mask must not keep the command bit");
  end
  if (rbc_pkg::MASK_SEC2[rbc_pkg::BIT_DECRYPT] != 1'b0) begin : g_bad_decrypt
    $error("security mask must not keep the decrypt bit");
  end
  if (rbc_pkg::MASK_SEC2[rbc_pkg::BIT_ENCRYPT] != 1'b0) begin : g_bad_encrypt
    $error("security mask must not keep the encrypt bit");
  end
  if (rbc_pkg::MASK_STRENGTH[rbc_pkg::BIT_SINGLE_MEAS] != 1'b0) begin : g_bad_measure
    $error("strength mask must not keep the measure bit");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic aw;
    logic [7:0] awIdx;
    logic awBad;
    logic w;
    logic [7:0] wByte;
    logic wLane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] sleepReg;
    logic [7:0] rfReg;
    logic [7:0] secReg;
    logic [7:0] rateReg;
    logic [7:0] polReg;
    logic [7:0] ccaReg;
    logic [7:0] preReg;
    logic [7:0] csReg;
    logic [7:0] strReg;
    logic decBusy;
    logic encBusy;
    logic measBusy;
    logic sleepPulse;
    logic decPulse;
    logic encPulse;
    logic measPulse;
    logic [31:0] calCount;
    logic awReady;
    logic wReady;
    logic arReady;
    logic calFlag;
    logic busyFlag;
  } rbc_state_s;

  rbc_state_s state_reg;
  rbc_state_s state_next;

  // word address to register index; misaligned or out of range maps to 0
  function automatic logic [8:0] rbc_decode(input logic [31:0] addr);
    logic [29:0] word;
    word = addr[31:2];
    if (addr[1:0] != 2'h0 || word > 30'h0FF) begin
      rbc_decode = {1'b1, 8'h00};
    end else begin
      rbc_decode = {1'b0, word[7:0]};
    end
  endfunction : rbc_decode

  function automatic logic rbc_known(input logic [7:0] idx);
    case (idx)
      rbc_pkg::IDX_SLEEP, rbc_pkg::IDX_RFMODE, rbc_pkg::IDX_SEC2, rbc_pkg::IDX_RATE,
      rbc_pkg::IDX_POLARITY, rbc_pkg::IDX_CCA, rbc_pkg::IDX_PREAMBLE,
      rbc_pkg::IDX_CSPRE, rbc_pkg::IDX_STRENGTH: rbc_known = 1'b1;
      default: rbc_known = 1'b0;
    endcase
  endfunction : rbc_known

  // a request outside the register set is answered with an error
  function automatic logic rbc_refused(input logic [8:0] dec);
    rbc_refused = dec[8] | ~rbc_known(dec[7:0]);
  endfunction : rbc_refused

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [8:0] dec;
    logic [7:0] v;
    logic wrHit;
    dec = 9'h000;
    v = 8'h00;
    wrHit = 1'b0;
    state_next = state_reg;
    state_next.sleepPulse = 1'b0;
    state_next.decPulse = 1'b0;
    state_next.encPulse = 1'b0;
    state_next.measPulse = 1'b0;

    // address and data taken in either order, one write at a time
    if (!state_reg.aw && !state_reg.bvalid && s_axi_awvalid) begin
      dec = rbc_decode(s_axi_awaddr);
      state_next.aw = 1'b1;
      state_next.awIdx = dec[7:0];
      state_next.awBad = rbc_refused(dec);
    end
    if (!state_reg.w && !state_reg.bvalid && s_axi_wvalid) begin
      state_next.w = 1'b1;
      state_next.wByte = s_axi_wdata[7:0];
      state_next.wLane = s_axi_wstrb[0];
    end

    // hardware completion clears command bits; a new write below may set them again
    if (state_reg.decBusy && cryptoDone) begin
      state_next.decBusy = 1'b0;
    end
    if (state_reg.encBusy && cryptoDone) begin
      state_next.encBusy = 1'b0;
    end
    if (state_reg.measBusy && strengthDone) begin
      state_next.measBusy = 1'b0;
    end
    // calibration wait after the rf reset bit falls
    if (state_reg.calCount != 32'h0) begin
      state_next.calCount = state_reg.calCount - 32'h1;
    end

    // commit once both halves are held
    if (state_reg.aw && state_reg.w) begin
      state_next.aw = 1'b0;
      state_next.w = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = state_reg.awBad ? rbc_pkg::RESP_SLVERR : rbc_pkg::RESP_OKAY;
      wrHit = ~state_reg.awBad & state_reg.wLane;
      v = state_reg.wByte;
    end
    if (wrHit) begin
      case (state_reg.awIdx)
        rbc_pkg::IDX_SLEEP: begin
          state_next.sleepReg = v & rbc_pkg::MASK_SLEEP;
          state_next.sleepPulse = v[rbc_pkg::BIT_SLEEP_CMD];
        end
        rbc_pkg::IDX_RFMODE: begin
          state_next.rfReg = v & rbc_pkg::MASK_RFMODE;
          if (state_reg.rfReg[rbc_pkg::BIT_RF_RESET] && !v[rbc_pkg::BIT_RF_RESET]) begin
            state_next.calCount = 32'(CAL_CYCLES);
          end
        end
        rbc_pkg::IDX_SEC2: begin
          state_next.secReg = v & rbc_pkg::MASK_SEC2;
          if (v[rbc_pkg::BIT_DECRYPT]) begin
            state_next.decBusy = 1'b1;
            state_next.decPulse = 1'b1;
          end
          if (v[rbc_pkg::BIT_ENCRYPT]) begin
            state_next.encBusy = 1'b1;
            state_next.encPulse = 1'b1;
          end
        end
        rbc_pkg::IDX_RATE: begin
          state_next.rateReg = v & rbc_pkg::MASK_RATE;
        end
        rbc_pkg::IDX_POLARITY: begin
          state_next.polReg = v & rbc_pkg::MASK_POLARITY;
        end
        rbc_pkg::IDX_CCA: begin
          state_next.ccaReg = v & rbc_pkg::MASK_CCA;
        end
        rbc_pkg::IDX_PREAMBLE: begin
          state_next.preReg = v & rbc_pkg::MASK_PREAMBLE;
        end
        rbc_pkg::IDX_CSPRE: begin
          state_next.csReg = v & rbc_pkg::MASK_CSPRE;
        end
        rbc_pkg::IDX_STRENGTH: begin
          state_next.strReg = v & rbc_pkg::MASK_STRENGTH;
          if (v[rbc_pkg::BIT_SINGLE_MEAS]) begin
            state_next.measBusy = 1'b1;
            state_next.measPulse = 1'b1;
          end
        end
        default: state_next.bresp = rbc_pkg::RESP_SLVERR;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // read: answer one cycle after the address is taken
    if (!state_reg.rvalid && s_axi_arvalid) begin
      dec = rbc_decode(s_axi_araddr);
      state_next.rvalid = 1'b1;
      state_next.rresp = rbc_refused(dec) ? rbc_pkg::RESP_SLVERR : rbc_pkg::RESP_OKAY;
      case (dec[7:0])
        // command bits always read zero once cleared
        rbc_pkg::IDX_SLEEP: state_next.rdata = state_reg.sleepReg;
        rbc_pkg::IDX_RFMODE: state_next.rdata = state_reg.rfReg;
        rbc_pkg::IDX_SEC2: state_next.rdata = state_reg.secReg
          | {state_reg.decBusy, state_reg.encBusy, 6'h00};
        rbc_pkg::IDX_RATE: state_next.rdata = state_reg.rateReg;
        rbc_pkg::IDX_POLARITY: state_next.rdata = state_reg.polReg;
        rbc_pkg::IDX_CCA: state_next.rdata = state_reg.ccaReg;
        rbc_pkg::IDX_PREAMBLE: state_next.rdata = state_reg.preReg;
        rbc_pkg::IDX_CSPRE: state_next.rdata = state_reg.csReg;
        rbc_pkg::IDX_STRENGTH: state_next.rdata = state_reg.strReg
          | {state_reg.measBusy, 6'h00, ~state_reg.measBusy};
        default: state_next.rdata = 8'h00;
      endcase
      if (dec[8]) begin
        state_next.rdata = 8'h00;
      end
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // readies and level flags are flops too, so derive them from the next state
    state_next.awReady = ~state_next.aw & ~state_next.bvalid;
    state_next.wReady = ~state_next.w & ~state_next.bvalid;
    state_next.arReady = ~state_next.rvalid;
    state_next.calFlag = (state_next.calCount != 32'h0);
    state_next.busyFlag = state_next.decBusy | state_next.encBusy;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.awReady <= 1'b1;
      state_reg.wReady <= 1'b1;
      state_reg.arReady <= 1'b1;
      state_reg.sleepReg <= rbc_pkg::RST_ZERO;
      state_reg.rfReg <= rbc_pkg::RST_ZERO;
      state_reg.secReg <= rbc_pkg::RST_ZERO;
      state_reg.ccaReg <= rbc_pkg::RST_CCA;
      state_reg.preReg <= rbc_pkg::RST_PREAMBLE;
      state_reg.csReg <= rbc_pkg::RST_CSPRE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // bus outputs
  // ----------------------------------------
  // readies are registered, so a request can never see a combinational loop
  assign s_axi_awready = state_reg.awReady;
  assign s_axi_wready = state_reg.wReady;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arReady;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rdata = {24'h000000, state_reg.rdata};

  // ----------------------------------------
  // sleep and rf control
  // ----------------------------------------
  // wake count is split across two registers but leaves as one word
  assign sleepRequest = state_reg.sleepPulse;
  assign oscillatorWakeCount = {state_reg.rfReg[4:3], state_reg.sleepReg[6:0]};
  assign rfMachineReset = state_reg.rfReg[rbc_pkg::BIT_RF_RESET];
  assign rfCalibrating = state_reg.calFlag;
  assign rfModeBits = state_reg.rfReg[1:0];

  // ----------------------------------------
  // security
  // ----------------------------------------
  // starts are one-cycle strobes; busy stays up until the engine reports done
  assign decryptStart = state_reg.decPulse;
  assign encryptStart = state_reg.encPulse;
  assign cryptoBusy = state_reg.busyFlag;
  assign slot2SuiteSelect = state_reg.secReg[5:3];
  assign slot1SuiteSelect = state_reg.secReg[2:0];

  // ----------------------------------------
  // baseband tuning
  // ----------------------------------------
  // plain fields, straight from the stored registers
  assign turboRate = state_reg.rateReg[0];
  assign symbolSignInvert = state_reg.polReg[2];
  assign channelAssessmentMode = state_reg.ccaReg[7:6];
  assign assessmentCarrierThreshold = state_reg.ccaReg[5:2];
  assign preambleValidThreshold = state_reg.preReg[7:4];
  assign preambleDetectThreshold = state_reg.preReg[3:1];
  assign carrierSenseThreshold = state_reg.csReg[7:5];
  assign preambleCounterThreshold = state_reg.csReg[4:2];

  // ----------------------------------------
  // signal strength
  // ----------------------------------------
  // one measurement per strobe; per-packet mode is a plain level
  assign strengthStart = state_reg.measPulse;
  assign perPacketStrength = state_reg.strReg[rbc_pkg::BIT_PER_PACKET];
endmodule : rbc_regs
`default_nettype wire

// >>> rbc_pkg.sv
`default_nettype none
package rbc_pkg;
  // ----------------------------------------
  // register indices; the byte address is four times the index
  // ----------------------------------------
  localparam logic [7:0] IDX_SLEEP = 8'h35;
  localparam logic [7:0] IDX_RFMODE = 8'h36;
  localparam logic [7:0] IDX_SEC2 = 8'h37;
  localparam logic [7:0] IDX_RATE = 8'h38;
  localparam logic [7:0] IDX_POLARITY = 8'h39;
  localparam logic [7:0] IDX_CCA = 8'h3A;
  localparam logic [7:0] IDX_PREAMBLE = 8'h3B;
  localparam logic [7:0] IDX_CSPRE = 8'h3C;
  localparam logic [7:0] IDX_STRENGTH = 8'h3E;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_SLEEP_CMD = 7;
  localparam int BIT_RF_RESET = 2;
  localparam int BIT_DECRYPT = 7;
  localparam int BIT_ENCRYPT = 6;
  localparam int BIT_SINGLE_MEAS = 7;
  localparam int BIT_PER_PACKET = 6;
  localparam int BIT_RESULT_READY = 0;
  // ----------------------------------------
  // writable masks and reset values
  // ----------------------------------------
  localparam logic [7:0] MASK_SLEEP = 8'h7F;
  localparam logic [7:0] MASK_RFMODE = 8'h1F;
  localparam logic [7:0] MASK_SEC2 = 8'h3F;
  localparam logic [7:0] MASK_RATE = 8'h01;
  localparam logic [7:0] MASK_POLARITY = 8'h04;
  localparam logic [7:0] MASK_CCA = 8'hFC;
  localparam logic [7:0] MASK_PREAMBLE = 8'hFE;
  localparam logic [7:0] MASK_CSPRE = 8'hFC;
  localparam logic [7:0] MASK_STRENGTH = 8'h40;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CCA = 8'h48;
  localparam logic [7:0] RST_PREAMBLE = 8'hD8;
  localparam logic [7:0] RST_CSPRE = 8'h9C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int RF_CAL_US = 192;
  localparam int RF_CAL_CYCLES = RF_CAL_US * CLK_MHZ;
endpackage : rbc_pkg
`default_nettype wire

// >>> rbc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rbc_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic sleepRequest,
  input wire logic rfMachineReset,
  input wire logic rfCalibrating,
  input wire logic decryptStart,
  input wire logic encryptStart,
  input wire logic strengthStart,
  input wire logic [1:0] channelAssessmentMode
);
  // ----------------------------------------
  // one clock domain, reset masks every check
  // ----------------------------------------
  default clocking monClk @(posedge clk); endclocking
  default disable iff (reset);
  // command strobes are single-cycle pulses
  sleep_pulse_a: assert property (sleepRequest |=> !sleepRequest)
    else $error("sleep request wider than one cycle");
  decrypt_pulse_a: assert property (decryptStart |=> !decryptStart)
    else $error("decrypt start wider than one cycle");
  encrypt_pulse_a: assert property (encryptStart |=> !encryptStart)
    else $error("encrypt start wider than one cycle");
  measure_pulse_a: assert property (strengthStart |=> !strengthStart)
    else $error("measure start wider than one cycle");
  // leaving rf reset must start the calibration wait
  rf_calibrate_a: assert property ($fell(rfMachineReset) |-> ##[0:1] rfCalibrating)
    else $error("no calibration after rf reset release");
  // clear-channel mode comes out of reset as carrier sense
  cca_default_a: assert property ($fell(reset) |-> channelAssessmentMode == 2'h1)
    else $error("clear-channel mode reset value wrong");
  // bus answers: fixed latency, held until accepted, byte wide
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte zero not clear");
endmodule : rbc_monitor
`default_nettype wire

// >>> radio_baseband_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module radio_baseband_control_regs_tb;
  // short calibration wait keeps the run brief
  localparam int CAL = 20;
  localparam logic [7:0] IDX [9] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3E};
  localparam logic [7:0] RST [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h48, 8'hD8, 8'h9C, 8'h01};
  localparam logic [7:0] ONES [9] = '{8'h7F, 8'h1F, 8'h3F, 8'h01, 8'h04, 8'hFC, 8'hFE, 8'hFC, 8'h40};
  logic clk = 1'b0, reset = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cryptoDone = 1'b0, strengthDone = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleepRequest;
  logic rfMachineReset, rfCalibrating, decryptStart, encryptStart, cryptoBusy, turboRate;
  logic symbolSignInvert, strengthStart, perPacketStrength;
  logic [1:0] s_axi_bresp, s_axi_rresp, rfModeBits, channelAssessmentMode;
  logic [8:0] oscillatorWakeCount;
  logic [2:0] slot2SuiteSelect, slot1SuiteSelect, preambleDetectThreshold;
  logic [2:0] carrierSenseThreshold, preambleCounterThreshold;
  logic [3:0] assessmentCarrierThreshold, preambleValidThreshold;
  int testsRun = 0, failures = 0, cycles = 0, nSleep = 0, nDec = 0, nEnc = 0, nMeas = 0;
  rbc_regs #(.CAL_CYCLES(CAL)) rbc_regs_i (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cryptoDone, .strengthDone, .sleepRequest,
    .oscillatorWakeCount, .rfMachineReset, .rfCalibrating, .rfModeBits, .decryptStart,
    .encryptStart, .cryptoBusy, .slot2SuiteSelect, .slot1SuiteSelect, .turboRate,
    .symbolSignInvert, .channelAssessmentMode, .assessmentCarrierThreshold,
    .preambleValidThreshold, .preambleDetectThreshold, .carrierSenseThreshold,
    .preambleCounterThreshold, .strengthStart, .perPacketStrength);
  // ----------------------------------------
  // clock, strobe counters and hang guard
  // ----------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    nSleep += int'(sleepRequest === 1'b1);
    nDec += int'(decryptStart === 1'b1);
    nEnc += int'(encryptStart === 1'b1);
    nMeas += int'(strengthStart === 1'b1);
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // bus tasks: ready raised late to exercise holding
  // ----------------------------------------
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
      input logic [1:0] resp = rbc_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, resp)
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
      input logic [1:0] resp = rbc_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {24'h0, exp})
    `CHK(s_axi_rresp, resp)
  endtask : rd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs;
    for (int i = 0; i < 9; i++) rd(IDX[i], RST[i]);
    for (int i = 0; i < 9; i++) begin
      wr(IDX[i], ONES[i]);
      rd(IDX[i], ONES[i] | 8'(i == 8));
    end
    `CHK(oscillatorWakeCount, 9'h1FF)
    `CHK({turboRate, symbolSignInvert, perPacketStrength}, 3'h7)
    for (int i = 0; i < 9; i++) wr(IDX[i], 8'h00);
    `CHK({turboRate, symbolSignInvert, perPacketStrength}, 3'h0)
    rd(8'h3D, 8'h00, rbc_pkg::RESP_SLVERR);
    wr(8'h3D, 8'h00, rbc_pkg::RESP_SLVERR);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_rf;
    wr(8'h35, 8'h5F);
    `CHK(oscillatorWakeCount, 9'h05F)
    wr(8'h36, 8'h06);
    `CHK({rfMachineReset, rfModeBits, oscillatorWakeCount}, 12'hC5F)
    wr(8'h36, 8'h1A);
    `CHK({rfMachineReset, rfCalibrating, oscillatorWakeCount}, 11'h3DF)
    repeat (CAL - 6) @(posedge clk);
    `CHK(rfCalibrating, 1'b1)
    repeat (10) @(posedge clk);
    `CHK(rfCalibrating, 1'b0)
    $display("test_rf done");
  endtask : test_rf
  // one self-clearing command: start, read busy, finish, read idle
  task automatic command(input logic [7:0] idx, input logic [7:0] d, input logic [7:0] idle);
    wr(idx, d);
    rd(idx, d);
    `CHK(cryptoBusy, 1'(idx == 8'h37))
    @(posedge clk);
    if (idx == 8'h3E) strengthDone <= 1'b1;
    else cryptoDone <= 1'b1;
    @(posedge clk);
    strengthDone <= 1'b0;
    cryptoDone <= 1'b0;
    rd(idx, idle);
    `CHK(cryptoBusy, 1'b0)
  endtask : command
  task automatic test_commands;
    wr(8'h35, 8'h80);
    repeat (2) @(posedge clk);
    `CHK(nSleep, 1)
    rd(8'h35, 8'h00);
    command(8'h37, 8'h80, 8'h00);
    `CHK(nDec, 1)
    command(8'h37, 8'h40, 8'h00);
    `CHK(nEnc, 1)
    command(8'h3E, 8'h80, 8'h01);
    `CHK(nMeas, 1)
    for (int c = 0; c < 8; c++) begin
      wr(8'h37, {2'h0, 3'(c), 3'(7 - c)});
      `CHK({slot2SuiteSelect, slot1SuiteSelect}, {3'(c), 3'(7 - c)})
    end
    $display("test_commands done");
  endtask : test_commands
  task automatic test_thresholds;
    for (int m = 1; m < 4; m++) begin
      wr(8'h3A, {2'(m), 4'hE, 2'h0});
      `CHK({channelAssessmentMode, assessmentCarrierThreshold}, {2'(m), 4'hE})
    end
    wr(8'h3B, 8'h36);
    `CHK({preambleValidThreshold, preambleDetectThreshold}, 7'h1B)
    wr(8'h3C, 8'h5C);
    `CHK({carrierSenseThreshold, preambleCounterThreshold}, 6'h17)
    $display("test_thresholds done");
  endtask : test_thresholds
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    test_regs();
    test_rf();
    test_commands();
    test_thresholds();
    print_verdict();
  end
endmodule : radio_baseband_control_regs_tb
bind rbc_regs rbc_monitor rbc_monitor_i (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sleepRequest,
  .rfMachineReset, .rfCalibrating, .decryptStart, .encryptStart, .strengthStart,
  .channelAssessmentMode);
`default_nettype wire
